// ### inc/fwp_defs.svh
// fwp_defs.svh: command codes, status bit positions, write masks
// assumes: included by the flash protection package and design files
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH

// command codes, one byte each
`define FWP_OP_WRITE_ENABLE_CMD     8'h06
`define FWP_OP_WRITE_DISABLE_CMD     8'h04
`define FWP_OP_SRW1     8'h01
`define FWP_OP_SRW2     8'h31
`define FWP_OP_SRW3     8'h11
`define FWP_OP_PP3      8'h02
`define FWP_OP_PP4      8'h12
`define FWP_OP_QPP3     8'h32
`define FWP_OP_QPP4     8'h34
`define FWP_OP_SE3      8'h20
`define FWP_OP_SE4      8'h21
`define FWP_OP_BE32_3   8'h52
`define FWP_OP_BE32_4   8'h5C
`define FWP_OP_BE64_3   8'hD8
`define FWP_OP_BE64_4   8'hDC
`define FWP_OP_CE_A     8'h60
`define FWP_OP_CE_B     8'hC7
`define FWP_OP_DPD      8'hB9
`define FWP_OP_REL      8'hAB
`define FWP_OP_RSTEN    8'h66
`define FWP_OP_RST      8'h99
`define FWP_OP_CLRF     8'h30

// low status byte bit positions
`define FWP_B_BUSY      0
`define FWP_B_WEL       1
`define FWP_B_BP_LSB    2
`define FWP_B_TB        6
`define FWP_B_STATUS_LOCK_BIT0      7
// middle status byte bit positions
`define FWP_B_QE        1
`define FWP_B_STATUS_LOCK_BIT1      6
// high status byte bit positions
`define FWP_B_PE        2
`define FWP_B_EE        3

// stored-bit masks per byte, and the one-time-programmable bits
`define FWP_SR1_WMASK   8'hFC
`define FWP_SR2_WMASK   8'h7A
`define FWP_SR3_WMASK   8'hF0
`define FWP_SR1_OTP     8'h40
`define FWP_SR2_OTP     8'h38

// geometry: block index starts at this address bit
`define FWP_BLK_LSB     16
`define FWP_BLK_BITS    9
`define FWP_ADDR_BITS   25

`endif

// ### inc/fwp_pkg.sv
// fwp_pkg: types of the flash write-protection block
// assumes: fwp_defs.svh is on the include path
package fwp_pkg;
  `include "fwp_defs.svh"

  // control states
  typedef enum logic [1:0] {
    fwp_st_load,
    fwp_st_idle,
    fwp_st_busy,
    fwp_st_dpd
  } fwp_state_t;

  // kind of array or register operation started
  typedef enum logic [2:0] {
    fwp_op_none,
    fwp_op_page,
    fwp_op_qpage,
    fwp_op_sector,
    fwp_op_block,
    fwp_op_chip,
    fwp_op_status
  } fwp_op_t;
endpackage : fwp_pkg

// ### rtl/fwp_region_decode.sv
// fwp_region_decode: block-protect decode against one block index
// assumes: combinational, fed from flops of the same clock
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_region_decode #(
  parameter int BLK_W = 9
) (
  // protection setting
  input  logic [3:0]       i_bp,
  input  logic             i_tb,
  // target block
  input  logic [BLK_W-1:0] i_blk,
  // results
  output logic             o_hit,
  output logic             o_any
);
  import fwp_pkg::*;

  localparam logic [BLK_W-1:0] ONES = {BLK_W{1'b1}};

  // the doubling ladder needs at least nine index bits
  if (BLK_W < `FWP_BLK_BITS) begin : g_chk
    $error("fwp_region_decode: BLK_W too small");
  end

  logic             all_w;
  logic [3:0]       lvl_w;
  logic [BLK_W-1:0] upper_w;
  logic [BLK_W-1:0] top_w;

  // protected size: 2^(bp-1) blocks, anchored top or bottom
  always_comb begin
    all_w   = (i_bp[3] & i_bp[2]) | (i_bp[3] & i_bp[1]); // R5
    lvl_w   = i_bp - 4'h1;
    upper_w = i_blk >> lvl_w;
    top_w   = ONES >> lvl_w;
    o_any   = (i_bp != 4'h0);
    if (!o_any) begin
      o_hit = 1'b0; // R5
    end else if (all_w) begin
      o_hit = 1'b1; // R5
    end else if (i_tb) begin
      o_hit = (upper_w == '0); // R6
    end else begin
      o_hit = (upper_w == top_w); // R6
    end
  end
endmodule : fwp_region_decode

// ### rtl/fwp_status_protect.sv
// fwp_status_protect: status register, write-enable latch and protection
// assumes: decoded, byte-complete commands arrive as one-cycle pulses on
// i_clk; the array sequencer reports the end of each started operation
//
// Operation
// R1: write-enable command sets the latch
// R2: latch cleared by reset and modifying commands
// R3: latch clear refuses register, program, erase
// R4: deep power-down accepts only release, reset
// R5: four protect bits decode the protected size
// R6: top/bottom bit anchors region high or low
// R7: top/bottom bit can only be set once
// R8: writes into the protected region are refused
// R9: whole-chip erase only when nothing protected
// R10: protect bits kept, changed by register write
// R11: protect bits writable only without hardware lock
// R12: hardware lock freezes protect and lock bits
// R13: busy flag high during any operation
// R14: lock bits 00 allow writes with latch
// R15: lock bits 01 follow the protect pin
// R16: lock bits 10 refuse writes until power
// R17: power cycle turns lock bits 10 into 00
// R18: lock bits 11 refuse writes for ever
// R19: protected program sets the program-fail flag
// R20: protected erase sets wipe flag; clear command
// R21: protect pin works only when quad is off
// R22: host enables writes and polls busy first
// R23: check protection before start, leave array alone
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_status_protect #(
  parameter int ADDR_W = `FWP_ADDR_BITS
) (
  // clock and reset
  input  logic                 i_clk,
  input  logic                 i_rst_n,
  // write-protect pin, asynchronous
  input  logic                 i_wp_n,
  // decoded command
  input  logic                 i_cmd_valid,
  input  logic [7:0]           i_cmd_op,
  input  logic [ADDR_W-1:0]    i_cmd_addr,
  input  logic [15:0]          i_cmd_data,
  input  logic                 i_cmd_two,
  // non-volatile store
  input  logic [23:0]          i_nv_image,
  output logic [23:0]          o_nv_image,
  output logic                 o_nv_write,
  // array sequencer
  output logic                 o_op_start,
  output fwp_pkg::fwp_op_t     o_op_kind,
  output logic [ADDR_W-1:0]    o_op_addr,
  input  logic                 i_op_done,
  // status as read by the host
  output logic [23:0]          o_status,
  output logic                 o_dpd
);
  import fwp_pkg::*;

  localparam int BLK_W = ADDR_W - `FWP_BLK_LSB;

  // the decode map is laid out for the full array
  if (ADDR_W < `FWP_ADDR_BITS) begin : g_chk
    $error("fwp_status_protect: ADDR_W too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // program commands
  function automatic logic is_prog(input logic [7:0] op);
    is_prog = (op == `FWP_OP_PP3) || (op == `FWP_OP_PP4) ||
              (op == `FWP_OP_QPP3) || (op == `FWP_OP_QPP4);
  endfunction : is_prog

  // sector and block erase commands
  function automatic logic is_wipe(input logic [7:0] op);
    is_wipe = (op == `FWP_OP_SE3) || (op == `FWP_OP_SE4) ||
              (op == `FWP_OP_BE32_3) || (op == `FWP_OP_BE32_4) ||
              (op == `FWP_OP_BE64_3) || (op == `FWP_OP_BE64_4);
  endfunction : is_wipe

  // status write commands
  function automatic logic is_srw(input logic [7:0] op);
    is_srw = (op == `FWP_OP_SRW1) || (op == `FWP_OP_SRW2) ||
             (op == `FWP_OP_SRW3);
  endfunction : is_srw

  // operation kind from command code
  function automatic fwp_op_t kind_of(input logic [7:0] op);
    if ((op == `FWP_OP_PP3) || (op == `FWP_OP_PP4)) begin
      kind_of = fwp_op_page;
    end else if ((op == `FWP_OP_QPP3) || (op == `FWP_OP_QPP4)) begin
      kind_of = fwp_op_qpage;
    end else if ((op == `FWP_OP_SE3) || (op == `FWP_OP_SE4)) begin
      kind_of = fwp_op_sector;
    end else begin
      kind_of = fwp_op_block;
    end
  endfunction : kind_of

  ////////////////////////////////////////////////////////////////////////
  // write-protect pin synchroniser

  logic wp_meta_reg;
  logic wp_sync_reg;

  // two flops before any use
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_meta_reg <= 1'b1;
      wp_sync_reg <= 1'b1;
    end else begin
      wp_meta_reg <= i_wp_n;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state and status bits

  fwp_state_t        state_reg, state_next;
  logic              wel_reg, wel_next;
  logic              pe_reg, pe_next;
  logic              ee_reg, ee_next;
  logic              arm_reg, arm_next;
  logic [7:0]        sr1_reg, sr1_next;
  logic [7:0]        sr2_reg, sr2_next;
  logic [7:0]        sr3_reg, sr3_next;
  logic              start_reg, start_next;
  fwp_op_t           kind_reg, kind_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              nvw_reg, nvw_next;
  logic [23:0]       stat_reg, stat_next;

  logic [3:0]        bp_w;
  logic [1:0]        srp_w;
  logic              wp_low_w;
  logic              srw_ok_w;
  logic              hit_w;
  logic              any_w;
  logic              acc_w;
  logic              swrst_w;

  assign bp_w     = sr1_reg[`FWP_B_BP_LSB +: 4];
  assign srp_w    = {sr2_reg[`FWP_B_STATUS_LOCK_BIT1], sr1_reg[`FWP_B_STATUS_LOCK_BIT0]};
  // pin acts as protect input only while quad mode is off
  assign wp_low_w = ~wp_sync_reg & ~sr2_reg[`FWP_B_QE]; // R21
  // lock modes: 00 free, 01 pin, 10 and 11 refused
  assign srw_ok_w = wel_reg & ((srp_w == 2'b00) |
                    ((srp_w == 2'b01) & ~wp_low_w)); // R14 R15 R16 R18 R11 R12
  assign acc_w    = i_cmd_valid & (state_reg == fwp_st_idle);
  assign swrst_w  = i_cmd_valid & arm_reg & (i_cmd_op == `FWP_OP_RST) &
                    (state_reg != fwp_st_busy) & (state_reg != fwp_st_load);

  // protection decode of the target block
  fwp_region_decode #(
    .BLK_W (BLK_W)
  ) u_region (
    .i_bp  (bp_w),
    .i_tb  (sr1_reg[`FWP_B_TB]),
    .i_blk (i_cmd_addr[ADDR_W-1:`FWP_BLK_LSB]),
    .o_hit (hit_w),
    .o_any (any_w)
  );

  // next-state logic of the whole block
  always_comb begin
    state_next = state_reg;
    wel_next   = wel_reg;
    pe_next    = pe_reg;
    ee_next    = ee_reg;
    arm_next   = arm_reg;
    sr1_next   = sr1_reg;
    sr2_next   = sr2_reg;
    sr3_next   = sr3_reg;
    start_next = 1'b0;
    kind_next  = kind_reg;
    addr_next  = addr_reg;
    nvw_next   = 1'b0;
    case (state_reg)
      fwp_st_load: begin
        // stored bits come back; lock-down until power cycle ends here
        sr1_next = i_nv_image[7:0] & `FWP_SR1_WMASK;
        sr2_next = i_nv_image[15:8] & `FWP_SR2_WMASK;
        sr3_next = i_nv_image[23:16] & `FWP_SR3_WMASK;
        if (i_nv_image[8 + `FWP_B_STATUS_LOCK_BIT1] & ~i_nv_image[`FWP_B_STATUS_LOCK_BIT0]) begin
          sr2_next[`FWP_B_STATUS_LOCK_BIT1] = 1'b0; // R17
        end
        state_next = fwp_st_idle;
      end
      fwp_st_busy: begin
        if (i_op_done) begin
          state_next = fwp_st_idle; // R13
        end
      end
      default: begin
        if (i_cmd_valid) begin
          arm_next = (i_cmd_op == `FWP_OP_RSTEN);
        end
        if (swrst_w) begin
          wel_next   = 1'b0; // R2
          pe_next    = 1'b0;
          ee_next    = 1'b0;
          state_next = fwp_st_idle; // R4
        end else if (state_reg == fwp_st_dpd) begin
          if (i_cmd_valid && (i_cmd_op == `FWP_OP_REL)) begin
            state_next = fwp_st_idle; // R4
          end
        end else if (i_cmd_valid) begin
          if (i_cmd_op == `FWP_OP_WRITE_ENABLE_CMD) begin
            wel_next = 1'b1; // R1
          end else if (i_cmd_op == `FWP_OP_WRITE_DISABLE_CMD) begin
            wel_next = 1'b0; // R2
          end else if (i_cmd_op == `FWP_OP_DPD) begin
            state_next = fwp_st_dpd;
          end else if (i_cmd_op == `FWP_OP_CLRF) begin
            pe_next = 1'b0; // R20
            ee_next = 1'b0; // R20
          end else if (is_srw(i_cmd_op) && srw_ok_w) begin
            // only this command changes the stored bits
            if (i_cmd_op == `FWP_OP_SRW1) begin
              sr1_next = (i_cmd_data[7:0] & `FWP_SR1_WMASK) |
                         (sr1_reg & `FWP_SR1_OTP); // R10 R7
              if (i_cmd_two) begin
                sr2_next = (i_cmd_data[15:8] & `FWP_SR2_WMASK) |
                           (sr2_reg & `FWP_SR2_OTP);
              end
            end else if (i_cmd_op == `FWP_OP_SRW2) begin
              sr2_next = (i_cmd_data[7:0] & `FWP_SR2_WMASK) |
                         (sr2_reg & `FWP_SR2_OTP);
            end else begin
              sr3_next = i_cmd_data[7:0] & `FWP_SR3_WMASK;
            end
            wel_next   = 1'b0; // R2
            nvw_next   = 1'b1;
            start_next = 1'b1;
            kind_next  = fwp_op_status;
            state_next = fwp_st_busy; // R13
          end else if ((is_prog(i_cmd_op) || is_wipe(i_cmd_op)) && wel_reg) begin // R3
            wel_next = 1'b0; // R2
            if (hit_w) begin
              // refused before start, array untouched
              pe_next = pe_reg | is_prog(i_cmd_op); // R8 R19 R23
              ee_next = ee_reg | is_wipe(i_cmd_op); // R8 R20 R23
            end else begin
              start_next = 1'b1;
              kind_next  = kind_of(i_cmd_op);
              addr_next  = i_cmd_addr;
              state_next = fwp_st_busy;
            end
          end else if (((i_cmd_op == `FWP_OP_CE_A) || (i_cmd_op == `FWP_OP_CE_B))
                       && wel_reg) begin // R3
            wel_next = 1'b0; // R2
            if (any_w) begin
              ee_next = 1'b1; // R9
            end else begin
              start_next = 1'b1;
              kind_next  = fwp_op_chip;
              addr_next  = '0;
              state_next = fwp_st_busy;
            end
          end
        end
      end
    endcase
    stat_next = {sr3_next, sr2_next, sr1_next};
    stat_next[16 + `FWP_B_PE] = pe_next;
    stat_next[16 + `FWP_B_EE] = ee_next;
    stat_next[`FWP_B_WEL]     = wel_next;
    stat_next[`FWP_B_BUSY]    = (state_next == fwp_st_busy); // R13
  end

  // registers of the whole block
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= fwp_st_load;
      wel_reg   <= 1'b0; // R2
      pe_reg    <= 1'b0;
      ee_reg    <= 1'b0;
      arm_reg   <= 1'b0;
      sr1_reg   <= 8'h00;
      sr2_reg   <= 8'h00;
      sr3_reg   <= 8'h00;
      start_reg <= 1'b0;
      kind_reg  <= fwp_op_none;
      addr_reg  <= '0;
      nvw_reg   <= 1'b0;
      stat_reg  <= 24'h000000;
    end else begin
      state_reg <= state_next;
      wel_reg   <= wel_next;
      pe_reg    <= pe_next;
      ee_reg    <= ee_next;
      arm_reg   <= arm_next;
      sr1_reg   <= sr1_next;
      sr2_reg   <= sr2_next;
      sr3_reg   <= sr3_next;
      start_reg <= start_next;
      kind_reg  <= kind_next;
      addr_reg  <= addr_next;
      nvw_reg   <= nvw_next;
      stat_reg  <= stat_next;
    end
  end

  // outputs from flops; o_dpd is decoded from state_reg
  assign o_nv_image = {sr3_reg, sr2_reg, sr1_reg};
  assign o_nv_write = nvw_reg;
  assign o_op_start = start_reg;
  assign o_op_kind  = kind_reg;
  assign o_op_addr  = addr_reg;
  assign o_status   = stat_reg;
  assign o_dpd      = (state_reg == fwp_st_dpd);

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_write_enable_cmd_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
    acc_w && (i_cmd_op == `FWP_OP_WRITE_ENABLE_CMD) |=> wel_reg && o_status[`FWP_B_WEL])
    else $error("write enable did not set the latch");

  a_write_disable_cmd_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    acc_w && (i_cmd_op == `FWP_OP_WRITE_DISABLE_CMD) |=> !wel_reg)
    else $error("write disable left the latch set");

  a_start_needs_wel: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
    o_op_start |-> $past(wel_reg) && !wel_reg)
    else $error("operation started without the latch");

  a_dpd_filter: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    (state_reg == fwp_st_dpd) && !swrst_w &&
    !(i_cmd_valid && (i_cmd_op == `FWP_OP_REL))
    |=> (state_reg == fwp_st_dpd) && !o_op_start && $stable(wel_reg))
    else $error("command acted in deep power-down");

  a_tb_once: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
    (state_reg != fwp_st_load) && sr1_reg[`FWP_B_TB] |=> sr1_reg[`FWP_B_TB])
    else $error("top/bottom bit was cleared");

  a_prot_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
    acc_w && wel_reg && hit_w && (is_prog(i_cmd_op) || is_wipe(i_cmd_op))
    |=> !o_op_start && (pe_reg || ee_reg) && (state_reg == fwp_st_idle))
    else $error("protected target was not refused");

  a_chip_clean: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
    o_op_start && (o_op_kind == fwp_op_chip) |-> $past(bp_w) == 4'h0)
    else $error("chip erase started with protection set");

  a_hw_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
    (state_reg == fwp_st_idle) && wp_low_w && (srp_w == 2'b01)
    |=> $stable(bp_w) && $stable(srp_w) && !o_nv_write)
    else $error("locked protect bits changed");

  a_busy_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    o_op_start |-> o_status[`FWP_B_BUSY] && (state_reg == fwp_st_busy))
    else $error("busy flag low while operation runs");

  a_lock_hard: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
    acc_w && srp_w[1] && is_srw(i_cmd_op) |=> !o_nv_write && !o_op_start)
    else $error("status write taken under hard lock");

  a_err_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
    pe_reg && !swrst_w && !(acc_w && (i_cmd_op == `FWP_OP_CLRF)) |=> pe_reg)
    else $error("program-fail flag lost without clear");
endmodule : fwp_status_protect

// ### tb/fwp_seq_model.sv
// fwp_seq_model: array sequencer and non-volatile store beside the block
// assumes: driven by the block's start and store pulses on the same clock
`timescale 1ns/1ps
module fwp_seq_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // block side
  input  wire logic        i_op_start,
  input  wire logic        i_nv_write,
  input  wire logic [23:0] i_nv_data,
  input  wire logic [4:0]  i_delay,
  output logic             o_op_done,
  output logic [23:0]      o_nv_image
);
  logic        run_reg;
  logic [4:0]  cnt_reg;
  logic [23:0] store_reg = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // store survives power cycles, so it has no reset
  always @(posedge i_clk) begin
    if (i_nv_write) store_reg <= i_nv_data;
  end
  assign o_nv_image = store_reg;

  // operation timer, prompt or slow as the bench asks
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg   <= 1'b0;
      cnt_reg   <= 5'h00;
      o_op_done <= 1'b0;
    end else begin
      o_op_done <= 1'b0;
      if (i_op_start) begin
        run_reg <= 1'b1;
        cnt_reg <= i_delay;
      end else if (run_reg) begin
        if (cnt_reg == 5'h00) begin
          o_op_done <= 1'b1;
          run_reg   <= 1'b0;
        end else cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end
endmodule : fwp_seq_model

// ### tb/flash_write_protection_status_test.sv
// flash_write_protection_status_test: self-checking bench of the protect block
// assumes: commands arrive decoded; the sequencer model ends each operation
`timescale 1ns/1ps
`include "fwp_defs.svh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module flash_write_protection_status_test;
  import fwp_pkg::*;
  logic        i_clk, i_rst_n, i_wp_n, i_cmd_valid, i_cmd_two, i_op_done;
  logic        o_nv_write, o_op_start, o_dpd, started, wrote;
  logic [7:0]  i_cmd_op;
  logic [24:0] i_cmd_addr, o_op_addr;
  logic [15:0] i_cmd_data;
  logic [23:0] i_nv_image, o_nv_image, o_status;
  logic [4:0]  delay;
  fwp_op_t     o_op_kind;
  int          n_errors, comparisons, cycles;
  localparam logic [7:0] OPS [10] = '{`FWP_OP_PP3, `FWP_OP_PP4, `FWP_OP_QPP3,
    `FWP_OP_QPP4, `FWP_OP_SE3, `FWP_OP_SE4, `FWP_OP_BE32_3, `FWP_OP_BE32_4,
    `FWP_OP_BE64_3, `FWP_OP_BE64_4};

  ////////////////////////////////////////////////////////////////////////////
  // design and sequencer model
  fwp_status_protect fwp_status_protect_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_wp_n(i_wp_n), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
    .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data), .i_cmd_two(i_cmd_two),
    .i_nv_image(i_nv_image), .o_nv_image(o_nv_image), .o_nv_write(o_nv_write),
    .o_op_start(o_op_start), .o_op_kind(o_op_kind), .o_op_addr(o_op_addr),
    .i_op_done(i_op_done), .o_status(o_status), .o_dpd(o_dpd));
  fwp_seq_model fwp_seq_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_op_start(o_op_start), .i_nv_write(o_nv_write), .i_nv_data(o_nv_image),
    .i_delay(delay), .o_op_done(i_op_done), .o_nv_image(i_nv_image));

  // clock and hang guard
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // expected protection of one block
  function automatic logic prot(input logic [3:0] bp, input logic tb,
                                input logic [8:0] blk);
    int n;
    if (bp == 4'h0) return 1'b0;
    if (bp[3] && (bp[2] || bp[1])) return 1'b1;
    n = 1 << (bp - 1);
    return tb ? (blk < n) : (blk >= 512 - n);
  endfunction : prot

  // one command, answer visible on return
  task automatic cmd(input logic [7:0] op, input logic [24:0] a, input logic [15:0] d);
    i_cmd_op    = op;
    i_cmd_addr  = a;
    i_cmd_data  = d;
    delay       = 5'($urandom_range(0, 15));
    i_cmd_valid = 1'b1;
    @(posedge i_clk);
    #1 i_cmd_valid = 1'b0;
    // start and store pulses stand only in the cycle after the take
    started = o_op_start;
    wrote   = o_nv_write;
    @(posedge i_clk);
    #1;
  endtask : cmd

  task automatic wait_idle();
    for (int k = 0; k < 40; k++) begin
      if (o_status[0] === 1'b0) return;
      @(posedge i_clk);
      #1;
    end
    `CHK("busy cleared in time", 1'b0, o_status[0])
  endtask : wait_idle

  // host enables writes first and waits for busy low
  task automatic wsr(input logic [15:0] d, input logic ex);
    cmd(`FWP_OP_WRITE_ENABLE_CMD, 25'h0, 16'h0);
    cmd(`FWP_OP_SRW1, 25'h0, d);
    `CHK("status write accepted", ex, wrote)
    if (wrote === 1'b1) `CHK("busy in status write", 1'b1, o_status[0])
    wait_idle();
  endtask : wsr

  task automatic pin(input logic v);
    i_wp_n = v;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : pin

  task automatic power_cycle();
    i_rst_n = 1'b0;
    repeat (16) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : power_cycle

  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int opi;
    int fb;
    logic h;
    logic tbv;
    logic [3:0] bpv;
    logic [8:0] blks [5];
    logic [24:0] av;
    fwp_op_t ek;
    {i_rst_n, i_cmd_valid, i_cmd_op, i_cmd_addr, i_cmd_data, delay} = '0;
    i_wp_n    = 1'b1;
    i_cmd_two = 1'b1;
    void'($urandom(32'h024CB33B));
    power_cycle();
    `CHK("status after power-up", 24'h000000, o_status)
    cmd(`FWP_OP_WRITE_ENABLE_CMD, 25'h0, 16'h0);
    `CHK("latch set", 1'b1, o_status[1])
    cmd(`FWP_OP_WRITE_DISABLE_CMD, 25'h0, 16'h0);
    `CHK("latch cleared", 1'b0, o_status[1])
    cmd(`FWP_OP_PP3, 25'h0, 16'h0);
    `CHK("program without latch", 1'b0, started)
    cmd(`FWP_OP_SRW1, 25'h0, 16'h0004);
    `CHK("status write without latch", 1'b0, wrote)
    cmd(`FWP_OP_DPD, 25'h0, 16'h0);
    `CHK("power-down entered", 1'b1, o_dpd)
    cmd(`FWP_OP_WRITE_ENABLE_CMD, 25'h0, 16'h0);
    `CHK("command in power-down", 1'b0, o_status[1])
    cmd(`FWP_OP_REL, 25'h0, 16'h0);
    `CHK("power-down left", 1'b0, o_dpd)
    // every protect setting, both anchors, edge and random blocks
    for (int t = 0; t < 2; t++) begin
      for (int b = 0; b < 16; b++) begin
        bpv = 4'(b);
        tbv = t[0];
        wsr({9'h000, tbv, bpv, 2'b00}, 1'b1);
        `CHK("protect bits", bpv, o_status[5:2])
        `CHK("top/bottom bit", tbv, o_status[6])
        blks = '{9'($urandom), 9'h000, 9'h1FF, 9'h0FF, 9'h100};
        for (int k = 0; k < 5; k++) begin
          opi = $urandom_range(0, 9);
          fb  = (opi < 4) ? 18 : 19;
          h   = prot(bpv, tbv, blks[k]);
          av  = {blks[k], 16'($urandom)};
          ek  = (opi < 2) ? fwp_op_page : (opi < 4) ? fwp_op_qpage :
                (opi < 6) ? fwp_op_sector : fwp_op_block;
          cmd(`FWP_OP_WRITE_ENABLE_CMD, 25'h0, 16'h0);
          cmd(OPS[opi], av, 16'h0);
          `CHK("array op started", !h, started)
          if (started === 1'b1) `CHK("op kind", ek, o_op_kind)
          if (started === 1'b1) `CHK("op address", av, o_op_addr)
          `CHK("fail flag", h, o_status[fb])
          `CHK("latch after op", 1'b0, o_status[1])
          if (started === 1'b1) `CHK("busy", 1'b1, o_status[0])
          wait_idle();
          `CHK("busy ended", 1'b0, o_status[0])
          cmd(`FWP_OP_CLRF, 25'h0, 16'h0);
          `CHK("flags cleared", 2'b00, o_status[19:18])
        end
        cmd(`FWP_OP_WRITE_ENABLE_CMD, 25'h0, 16'h0);
        cmd(`FWP_OP_CE_A, 25'h0, 16'h0);
        `CHK("chip erase started", bpv == 4'h0, started)
        if (started === 1'b1) `CHK("chip erase kind", fwp_op_chip, o_op_kind)
        if (started === 1'b1) `CHK("chip erase address", 25'h0, o_op_addr)
        wait_idle();
        cmd(`FWP_OP_CLRF, 25'h0, 16'h0);
      end
    end
    wsr(16'h0000, 1'b1);
    `CHK("top/bottom stays set", 1'b1, o_status[6])
    // lock modes against the pin and quad mode
    wsr(16'h00C0, 1'b1);
    pin(1'b0);
    wsr(16'h00C4, 1'b0);
    `CHK("frozen protect bits", 4'h0, o_status[5:2])
    pin(1'b1);
    wsr(16'h02C0, 1'b1);
    pin(1'b0);
    wsr(16'h00C0, 1'b1);
    wsr(16'h00C0, 1'b0);
    pin(1'b1);
    wsr(16'h0040, 1'b1);
    pin(1'b0);
    wsr(16'h4040, 1'b1);
    wsr(16'h0040, 1'b0);
    pin(1'b1);
    wsr(16'h0040, 1'b0);
    power_cycle();
    `CHK("lock bits after power", 2'b00, {o_status[14], o_status[7]})
    // software reset, also from power-down
    cmd(`FWP_OP_WRITE_ENABLE_CMD, 25'h0, 16'h0);
    cmd(`FWP_OP_RSTEN, 25'h0, 16'h0);
    cmd(`FWP_OP_RST, 25'h0, 16'h0);
    `CHK("latch after soft reset", 1'b0, o_status[1])
    cmd(`FWP_OP_DPD, 25'h0, 16'h0);
    cmd(`FWP_OP_RSTEN, 25'h0, 16'h0);
    cmd(`FWP_OP_RST, 25'h0, 16'h0);
    `CHK("soft reset in power-down", 1'b0, o_dpd)
    // single-byte writes of the mid and high bytes
    cmd(`FWP_OP_WRITE_ENABLE_CMD, 25'h0, 16'h0);
    cmd(`FWP_OP_SRW3, 25'h0, 16'h00F0);
    `CHK("high byte written", 4'hF, o_status[23:20])
    wait_idle();
    cmd(`FWP_OP_WRITE_ENABLE_CMD, 25'h0, 16'h0);
    cmd(`FWP_OP_SRW2, 25'h0, 16'h0002);
    `CHK("mid byte written", 1'b1, o_status[9])
    wait_idle();
    i_cmd_two = 1'b0;
    wsr(16'h4040, 1'b1);
    `CHK("one-byte write keeps mid", 2'b01, {o_status[14], o_status[9]})
    i_cmd_two = 1'b1;
    wsr(16'h40C0, 1'b1);
    wsr(16'h0040, 1'b0);
    power_cycle();
    `CHK("permanent lock", 2'b11, {o_status[14], o_status[7]})
    wsr(16'h0040, 1'b0);
    complete_run();
  end
endmodule : flash_write_protection_status_test
